// ### design/rx_loop_code_alarm_status.sv
/*
  Receive loop-code and alarm status block of one line channel, with its
  register port, change flags and interrupt request.
  Assumes the alarm detectors and the recovered bit strobe arrive as pins
  from another clock domain; the register master runs on sys_clk.
*/
`timescale 1ns/10ps
module rx_loop_code_alarm_status
  import rx_alarm_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = LOOP_HOLD_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              rx_bit_stb,
  input  wire logic              rx_bit_data,
  input  wire logic              all_ones_detect,
  input  wire logic              signal_lost_detect,
  input  wire logic              prbs_lock_detect,
  output logic                   remote_loopback,
  output logic                   irq
);

  typedef struct packed {
    logic [1:0]        mode;
    loop_state_t       state;
    logic [STAT_W-1:0] irq_en;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] pend;
    logic              stb_prev;
    logic              loopback;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } top_state_t;

  top_state_t        s;
  top_state_t        next_s;
  logic [1:0]        rst_pipe;
  logic              rst_n;
  logic [4:0]        pins_sync;
  logic              bit_stb;
  logic              restart;
  logic              ctrl_wr;
  logic [1:0]        mode_eff;
  logic              up_seen;
  logic              down_seen;
  logic [STAT_W-1:0] change;

  // Release the asynchronous reset through two flops.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Bring the pin inputs into the sys_clk domain.
  bit_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({rx_bit_stb, rx_bit_data, all_ones_detect, signal_lost_detect, prbs_lock_detect}),
    .sync_out (pins_sync)
  );

  // One pulse per received bit, taken from the rising edge of the synchronised strobe.
  assign bit_stb  = pins_sync[4] & ~s.stb_prev;
  assign ctrl_wr  = wr && (addr == REG_CTRL);
  assign mode_eff = ctrl_wr ? wdata[1:0] : s.mode;
  assign restart  = ctrl_wr && (wdata[1:0] != s.mode);

  // Code persistence timing; restarted whenever the mode changes.
  loop_code_detector #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_loop_det (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .restart   (restart),
    .bit_stb   (bit_stb),
    .bit_val   (pins_sync[3]),
    .up_seen   (up_seen),
    .down_seen (down_seen)
  );

  // Next state: register writes, loop-code control, status, change flags and read data.
  always_comb begin
    next_s          = s;
    next_s.stb_prev = pins_sync[4];
    next_s.mode     = mode_eff;
    if (wr && (addr == REG_IRQ_EN)) begin
      next_s.irq_en = wdata[STAT_W-1:0];
    end
    next_s.stat[BIT_LOOP] = 1'b0;
    next_s.loopback       = 1'b0;
    if (mode_eff == MODE_OFF) begin
      next_s.state = LOOP_OFF;
    end else if (mode_eff != MODE_AUTO) begin
      next_s.state          = LOOP_MANUAL;
      next_s.stat[BIT_LOOP] = (s.state == LOOP_MANUAL) && (up_seen || down_seen);
    end else begin
      case (s.state)
        LOOP_AUTO_UP: begin
          if (up_seen) begin
            next_s.state          = LOOP_AUTO_LOOPED;
            next_s.stat[BIT_LOOP] = 1'b1;
            next_s.loopback       = 1'b1;
          end
        end
        LOOP_AUTO_LOOPED: begin
          if (down_seen) begin
            next_s.state = LOOP_AUTO_UP;
          end else begin
            next_s.stat[BIT_LOOP] = 1'b1;
            next_s.loopback       = 1'b1;
          end
        end
        default: begin
          next_s.state = LOOP_AUTO_UP;
        end
      endcase
    end
    next_s.stat[BIT_AIS]  = pins_sync[2];
    next_s.stat[BIT_LOS]  = pins_sync[1];
    next_s.stat[BIT_PRBS] = pins_sync[0];
    change                = next_s.stat ^ s.stat;
    next_s.pend           = s.pend;
    if (rd && (addr == REG_PEND)) begin
      next_s.pend = '0;
    end
    if (wr && (addr == REG_PEND_CLR)) begin
      next_s.pend = next_s.pend & ~wdata[STAT_W-1:0];
    end
    next_s.pend  = next_s.pend | change;
    next_s.irq   = |(next_s.pend & next_s.irq_en);
    next_s.rdata = 8'h00;
    if (rd) begin
      case (addr)
        REG_CTRL:   next_s.rdata = {6'h00, s.mode};
        REG_IRQ_EN: next_s.rdata = {4'h0, s.irq_en};
        REG_STATUS: next_s.rdata = {4'h0, s.stat};
        REG_PEND:   next_s.rdata = {4'h0, s.pend};
        default:    next_s.rdata = 8'h00;
      endcase
    end
  end

  // Register all state; frozen while the clock enable is low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.mode     <= CTRL_RESET;
      s.state    <= LOOP_OFF;
      s.irq_en   <= IRQ_EN_RESET;
      s.stat     <= STAT_RESET;
      s.pend     <= STAT_RESET;
      s.stb_prev <= 1'b0;
      s.loopback <= 1'b0;
      s.irq      <= 1'b0;
      s.rdata    <= 8'h00;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign rdata           = s.rdata;
  assign remote_loopback = s.loopback;
  assign irq             = s.irq;

  // Checks on the loop-code control, the change flags and the interrupt.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic [STAT_W-1:0] live_pins;
  assign live_pins = {1'b0, pins_sync[2:0]};

  sequence enter_auto;
    clk_en && ctrl_wr && (wdata[1:0] == MODE_AUTO) && (s.mode != MODE_AUTO);
  endsequence

  sequence looped_steady;
    clk_en && !ctrl_wr && (s.state == LOOP_AUTO_LOOPED);
  endsequence

  a_off_no_loop: assert property ((s.state == LOOP_OFF) && $past(s.state == LOOP_OFF)
    |-> !s.stat[BIT_LOOP] && !s.loopback)
    else $error("Loop status or loop-back active with detection off.");

  a_auto_entry_clear: assert property (enter_auto
    |=> !s.stat[BIT_LOOP] && !s.loopback && (s.state == LOOP_AUTO_UP))
    else $error("Entering automatic mode did not clear loop status.");

  a_auto_loop_set: assert property (clk_en && !ctrl_wr && (s.state == LOOP_AUTO_UP) && up_seen
    |=> s.stat[BIT_LOOP] && s.loopback && (s.state == LOOP_AUTO_LOOPED))
    else $error("Persisting loop-up code did not start loop-back.");

  a_auto_loop_hold: assert property (looped_steady ##0 !down_seen
    |=> s.stat[BIT_LOOP] && s.loopback)
    else $error("Loop status dropped while loop-back active.");

  a_auto_release: assert property (looped_steady ##0 down_seen
    |=> !s.stat[BIT_LOOP] && !s.loopback ##0 s.pend[BIT_LOOP])
    else $error("Persisting loop-down code did not release loop-back.");

  a_manual_follow: assert property (clk_en && !ctrl_wr && (s.state == LOOP_MANUAL)
    |=> s.stat[BIT_LOOP] == $past(up_seen || down_seen))
    else $error("Manual loop status does not follow code presence.");

  a_live_alarms: assert property (clk_en ##1 clk_en
    |-> s.stat[2:0] == $past(live_pins[2:0]))
    else $error("Alarm status bits do not follow the detector pins.");

  a_change_flag: assert property (clk_en && (next_s.stat != s.stat)
    |=> (s.pend & $past(change)) == $past(change))
    else $error("Status transition did not latch its change flag.");

  a_read_clears: assert property (clk_en && rd && (addr == REG_PEND) && (change == '0)
    |=> (s.pend == '0) && (s.rdata == {4'h0, $past(s.pend)}))
    else $error("Reading the change flags did not clear them.");

  a_irq_level: assert property (clk_en && !(wr || rd) && (change == '0) ##1 clk_en
    |-> s.irq == |(s.pend & s.irq_en))
    else $error("Interrupt output disagrees with enabled pending flags.");

  a_irq_masked: assert property ((s.irq_en == '0) ##1 (s.irq_en == '0)
    |-> !s.irq)
    else $error("Interrupt raised with every enable cleared.");

  // A settled manual cycle with no mode write in it.
  sequence manual_steady;
    clk_en && !ctrl_wr && (s.state == LOOP_MANUAL);
  endsequence

  // A settled automatic cycle that still waits for the loop-up code.
  sequence auto_searching;
    clk_en && !ctrl_wr && (s.state == LOOP_AUTO_UP);
  endsequence

  // A code that has persisted sets the manual status on the next edge.
  a_manual_set_status: assert property (manual_steady ##0 (up_seen || down_seen)
    |=> s.stat[BIT_LOOP])
    else $error("Manual loop status not set by a persisting code.");

  // The manual status drops as soon as neither code is present.
  a_manual_clear_status: assert property (manual_steady ##0 !(up_seen || down_seen)
    |=> !s.stat[BIT_LOOP])
    else $error("Manual loop status kept without a loop code.");

  // Every manual status transition latches the loop change flag.
  a_manual_edge_flag: assert property (manual_steady ##0 (next_s.stat[BIT_LOOP] != s.stat[BIT_LOOP])
    |=> s.pend[BIT_LOOP])
    else $error("Manual loop status transition not flagged.");

  // Manual mode only reports codes; it never loops the line back.
  a_manual_no_loopback: assert property ((s.state == LOOP_MANUAL)
    |-> !s.loopback)
    else $error("Loop-back active in manual mode.");

  // While searching, nothing but a persisting loop-up code sets the status.
  a_auto_search_quiet: assert property (auto_searching ##0 !up_seen
    |=> !s.stat[BIT_LOOP] && !s.loopback)
    else $error("Loop status set without a persisting loop-up code.");

  // Loop-back is only ever active together with the looped state and status.
  a_loopback_state: assert property (s.loopback
    |-> (s.state == LOOP_AUTO_LOOPED) && s.stat[BIT_LOOP])
    else $error("Loop-back active outside the looped state.");

  // Any change of the loop status in automatic mode latches its flag.
  a_auto_edge_flag: assert property (clk_en && !ctrl_wr && (s.mode == MODE_AUTO)
    && (next_s.stat[BIT_LOOP] != s.stat[BIT_LOOP]) |=> s.pend[BIT_LOOP])
    else $error("Automatic loop status change not flagged.");

  // Releasing loop-back raises the interrupt when the loop source is enabled.
  a_release_irq: assert property (looped_steady ##0 (down_seen && !wr && s.irq_en[BIT_LOOP])
    |=> s.irq)
    else $error("Loop-back release raised no enabled interrupt.");

  // An all-ones alarm transition latches its change flag.
  a_ais_edge_flag: assert property (clk_en && (pins_sync[2] != s.stat[BIT_AIS])
    |=> s.pend[BIT_AIS])
    else $error("All-ones alarm transition not flagged.");

  // A signal loss transition latches its change flag.
  a_los_edge_flag: assert property (clk_en && (pins_sync[1] != s.stat[BIT_LOS])
    |=> s.pend[BIT_LOS])
    else $error("Signal loss transition not flagged.");

  // A pattern sync transition latches its change flag.
  a_prbs_edge_flag: assert property (clk_en && (pins_sync[0] != s.stat[BIT_PRBS])
    |=> s.pend[BIT_PRBS])
    else $error("Pattern sync transition not flagged.");

  // A write to the enable register lands on the next edge.
  a_enable_write: assert property (clk_en && wr && (addr == REG_IRQ_EN)
    |=> s.irq_en == $past(wdata[STAT_W-1:0]))
    else $error("Interrupt enable write did not land.");

  // An enabled pending flag drives the interrupt high on the next edge.
  a_irq_enabled_pend: assert property (clk_en && (|(next_s.pend & next_s.irq_en))
    |=> s.irq)
    else $error("Enabled pending flag raised no interrupt.");

  // A status read returns the live status in the following cycle.
  a_status_read: assert property (clk_en && rd && (addr == REG_STATUS)
    |=> s.rdata == {4'h0, $past(s.stat)})
    else $error("Status read returned the wrong value.");

  // With detection off the loop status and loop-back stay low.
  a_off_status_zero: assert property ((s.mode == MODE_OFF)
    |-> !s.loopback && !s.stat[BIT_LOOP])
    else $error("Loop status or loop-back set with mode off.");

  // A write of ones to the clear register drops those flags when nothing changes.
  a_pend_clear_write: assert property (clk_en && wr && (addr == REG_PEND_CLR) && (change == '0)
    |=> (s.pend & $past(wdata[STAT_W-1:0])) == '0)
    else $error("Writing the clear register left flags set.");

endmodule

// ### design/rx_alarm_pkg.sv
/*
  Shared constants for the receive loop-code and alarm status block:
  register offsets, status bit positions, mode codes, reset values and timing.
  Assumes nothing of its surroundings; imported whole by every design module.
*/
package rx_alarm_pkg;

  // Register bus widths.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] REG_CTRL     = 3'h0;  // Loop-code mode select, bits 1:0.
  localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 3'h1;  // Interrupt enables, status layout.
  localparam logic [ADDR_W-1:0] REG_STATUS   = 3'h2;  // Live receive alarm status, read only.
  localparam logic [ADDR_W-1:0] REG_PEND     = 3'h3;  // Sticky change flags, cleared by a read.
  localparam logic [ADDR_W-1:0] REG_PEND_CLR = 3'h4;  // Write-only, a one clears that flag.

  // Status bit positions, shared by status, enable and pending registers.
  localparam int STAT_W   = 4;
  localparam int BIT_PRBS = 0;
  localparam int BIT_LOS  = 1;
  localparam int BIT_AIS  = 2;
  localparam int BIT_LOOP = 3;

  // Loop-code mode select codes; 01 and 10 are both manual.
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // Values after reset.
  localparam logic [1:0]        CTRL_RESET   = 2'h0;
  localparam logic [STAT_W-1:0] IRQ_EN_RESET = 4'h0;
  localparam logic [STAT_W-1:0] STAT_RESET   = 4'h0;

  // Loop codes: one mark in every five bits up, one in every three bits down.
  localparam int UP_LEN   = 5;
  localparam int DOWN_LEN = 3;

  // Persistence time of a loop code and its count of system clock cycles.
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned LOOP_HOLD_S      = 5;
  localparam int unsigned LOOP_HOLD_CYCLES = LOOP_HOLD_S * CLK_HZ;

  // Loop-code control states.
  typedef enum logic [1:0] {
    LOOP_OFF,
    LOOP_MANUAL,
    LOOP_AUTO_UP,
    LOOP_AUTO_LOOPED
  } loop_state_t;

endpackage

// ### design/bit_sync.sv
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes a synchronised active-low reset copy, used as an asynchronous reset, and a clock enable from the top.
*/
`timescale 1ns/10ps
module bit_sync
  import rx_alarm_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // The first stage feeds only the second stage.
  always_comb begin
    next_s        = s;
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  // Register the stages; frozen while the clock enable is low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule

// ### design/loop_code_detector.sv
/*
  Loop-up and loop-down code detector on the synchronised receive bit stream.
  Assumes one bit_stb pulse per received bit and a restart pulse on mode change.
*/
`timescale 1ns/10ps
module loop_code_detector
  import rx_alarm_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = LOOP_HOLD_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic restart,
  input  wire logic bit_stb,
  input  wire logic bit_val,
  output logic      up_seen,
  output logic      down_seen
);

  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD = CNT_W'(HOLD_CYCLES);

  typedef struct packed {
    logic [UP_LEN-1:0] shift;
    logic [2:0]        fill;
    logic [CNT_W-1:0]  up_cnt;
    logic [CNT_W-1:0]  down_cnt;
    logic              up_seen;
    logic              down_seen;
  } det_state_t;

  det_state_t s;
  det_state_t next_s;
  logic       up_match;
  logic       down_match;

  // A window holds one of the codes when it carries exactly one mark.
  assign up_match   = (s.fill >= 3'(UP_LEN)) && $onehot(s.shift);
  assign down_match = (s.fill >= 3'(DOWN_LEN)) && $onehot(s.shift[DOWN_LEN-1:0]);

  // Shift in bits and time how long each code has been present without a break.
  always_comb begin
    next_s = s;
    if (bit_stb) begin
      next_s.shift = {s.shift[UP_LEN-2:0], bit_val};
      if (s.fill != 3'(UP_LEN)) begin
        next_s.fill = s.fill + 3'h1;
      end
    end
    if (!up_match) begin
      next_s.up_cnt  = '0;
      next_s.up_seen = 1'b0;
    end else if (s.up_cnt != HOLD) begin
      next_s.up_cnt = s.up_cnt + 1'b1;
    end else begin
      next_s.up_seen = 1'b1;
    end
    if (!down_match) begin
      next_s.down_cnt  = '0;
      next_s.down_seen = 1'b0;
    end else if (s.down_cnt != HOLD) begin
      next_s.down_cnt = s.down_cnt + 1'b1;
    end else begin
      next_s.down_seen = 1'b1;
    end
    if (restart) begin
      next_s = '0;
    end
  end

  // Register the detector state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign up_seen   = s.up_seen;
  assign down_seen = s.down_seen;

endmodule

// ### verification/line_far_end.sv
/*
  Far-end line equipment model that sends loop-up, loop-down or all-ones bits.
  Assumes the bench selects the pattern; the strobe stands low while idle.
*/
`timescale 1ns/10ps
module line_far_end (
  input  wire logic       sys_clk,
  input  wire logic [1:0] pat,
  output logic            bit_stb,
  output logic            bit_data
);
  logic [2:0] ph;
  logic [2:0] pos;

  // Start quiet so the receiver sees no bit before a pattern is chosen.
  initial begin
    ph = 3'h0;
    pos = 3'h0;
    bit_stb = 1'b0;
    bit_data = 1'b0;
  end

  // Eight clocks per bit; data moves well before the strobe rises.
  always @(posedge sys_clk) begin
    ph <= ph + 3'h1;
    if (pat == 2'h0) begin
      bit_stb <= 1'b0;
      bit_data <= ~bit_data;  // Idle line toggles so stale data is never mistaken.
    end else begin
      bit_stb <= (ph >= 3'h2) && (ph <= 3'h5);
      if (ph == 3'h7) begin
        pos <= (pos >= ((pat == 2'h1) ? 3'h4 : 3'h2)) ? 3'h0 : pos + 3'h1;
        bit_data <= (pat == 2'h3) || (pos == 3'h0);
      end
    end
  end
endmodule

// ### verification/testbench.sv
/*
  Self-checking bench for the receive loop-code and alarm status block.
  Assumes the far-end model drives the bit stream and the bench owns the register port.
*/
`timescale 1ns/10ps
module testbench;
  import rx_alarm_pkg::*;
  logic              sys_clk;
  logic              nrst;
  logic              clk_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              stb;
  logic              bdat;
  logic [2:0]        alarm;
  logic [1:0]        pat;
  logic              remote_loopback;
  logic              irq;
  logic [7:0]        d;
  logic [2:0]        prev;
  logic [2:0]        pend;
  logic [31:0]       seed;
  int                errors;
  int                checked;
  int                n;

  rx_loop_code_alarm_status #(.HOLD_CYCLES(20)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_bit_stb(stb), .rx_bit_data(bdat), .all_ones_detect(alarm[2]),
    .signal_lost_detect(alarm[1]), .prbs_lock_detect(alarm[0]), .remote_loopback(remote_loopback), .irq(irq));

  line_far_end u_far (.sys_clk(sys_clk), .pat(pat), .bit_stb(stb), .bit_data(bdat));

  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd_reg(input logic [2:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_stat(input logic v);
    n = 0;
    rd_reg(REG_STATUS);
    while (d[3] !== v && n < 300) begin
      rd_reg(REG_STATUS);
      n++;
    end
  endtask

  task automatic wait_lb(input logic v);
    n = 0;
    while (remote_loopback !== v && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic print_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog of 20000 cycles, well beyond the expected run of about a thousand cycles.
  initial begin
    #400000;
    errors++;
    print_verdict;
  end

  // Main sequence: reset values, alarm bits, manual, automatic and off modes.
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    alarm = 3'h0;
    pat = 2'h0;
    seed = 32'h1F4A;
    errors = 0;
    checked = 0;
    prev = 3'h0;
    pend = 3'h0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rd_reg(i[2:0]);
      chk(d, 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      wr_reg(REG_IRQ_EN, {4'h0, seed[7:4]});
      alarm <= seed[2:0];
      pend = pend | (prev ^ seed[2:0]);
      prev = seed[2:0];
      repeat (5) @(posedge sys_clk);
      rd_reg(REG_STATUS);
      chk(d, {5'h0, prev});
      chk({7'h0, irq}, {7'h0, |(pend & seed[6:4])});
      if (seed[8]) begin
        rd_reg(REG_PEND);
        chk(d, {5'h0, pend});
        pend = 3'h0;
      end else if (seed[9]) begin
        wr_reg(REG_PEND_CLR, 8'h07);
        pend = 3'h0;
      end
    end
    clk_en <= 1'b0;
    alarm <= ~prev;
    repeat (6) @(posedge sys_clk);
    clk_en <= 1'b1;
    rd_reg(REG_STATUS);
    chk(d, {5'h0, prev});
    prev = ~prev;
    repeat (5) @(posedge sys_clk);
    rd_reg(REG_STATUS);
    chk(d, {5'h0, prev});
    wr_reg(REG_IRQ_EN, 8'h08);
    for (int m = 1; m < 3; m++) begin
      rd_reg(REG_PEND);
      wr_reg(REG_CTRL, m[7:0]);
      pat <= m[1:0];
      repeat (28) @(posedge sys_clk);
      rd_reg(REG_STATUS);
      chk(d & 8'h08, 8'h00);
      wait_stat(1'b1);
      chk({d[3], remote_loopback}, 8'h02);
      repeat (40) @(posedge sys_clk);
      rd_reg(REG_STATUS);
      chk(d & 8'h08, 8'h08);
      chk({7'h0, irq}, 8'h01);
      rd_reg(REG_PEND);
      chk(d, 8'h08);
      pat <= 2'h3;
      wait_stat(1'b0);
      chk(d & 8'h08, 8'h00);
      rd_reg(REG_PEND);
      chk(d, 8'h08);
    end
    wr_reg(REG_CTRL, 8'h03);
    rd_reg(REG_STATUS);
    chk(d & 8'h08, 8'h00);
    rd_reg(REG_PEND);
    pat <= 2'h2;
    repeat (150) @(posedge sys_clk);
    rd_reg(REG_STATUS);
    chk({d[3], remote_loopback}, 8'h00);
    pat <= 2'h1;
    wait_lb(1'b1);
    rd_reg(REG_STATUS);
    chk(d & 8'h08, 8'h08);
    chk({7'h0, irq}, 8'h01);
    rd_reg(REG_PEND);
    chk(d, 8'h08);
    pat <= 2'h3;
    repeat (150) @(posedge sys_clk);
    rd_reg(REG_STATUS);
    chk({d[3], remote_loopback}, 8'h03);
    pat <= 2'h2;
    wait_lb(1'b0);
    rd_reg(REG_STATUS);
    chk(d & 8'h08, 8'h00);
    chk({7'h0, irq}, 8'h01);
    rd_reg(REG_PEND);
    chk(d, 8'h08);
    wr_reg(REG_CTRL, 8'h00);
    pat <= 2'h1;
    repeat (150) @(posedge sys_clk);
    rd_reg(REG_STATUS);
    chk({d[3], remote_loopback}, 8'h00);
    print_verdict;
  end
endmodule
